// ### shared/loop_autotune_pkg.sv
// Package of constants, types and register map for the loop autotune and on/off controller.
package loop_autotune_pkg;

    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned TUNE_MIN_MS     = 50;
    localparam int unsigned TUNE_MAX_MS     = 200;
    localparam int unsigned PERIOD_SEC_S    = 1;
    localparam int unsigned PERIOD_MIN_S    = 60;
    localparam int unsigned TUNE_MIN_CYC    = CLK_HZ / 1000 * TUNE_MIN_MS;
    localparam int unsigned TUNE_MAX_CYC    = CLK_HZ / 1000 * TUNE_MAX_MS;
    localparam int unsigned SEC_CYC         = CLK_HZ * PERIOD_SEC_S;
    localparam int unsigned MIN_CYC         = CLK_HZ * PERIOD_MIN_S;

    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_TUNE_CFG   = 8'h04;
    localparam logic [7:0]  ADDR_GAIN       = 8'h08;
    localparam logic [7:0]  ADDR_CMD        = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS     = 8'h10;
    localparam logic [7:0]  ADDR_COEF_A     = 8'h14;
    localparam logic [7:0]  ADDR_COEF_B     = 8'h18;
    localparam logic [7:0]  ADDR_COEF_C     = 8'h1C;
    localparam logic [7:0]  ADDR_USER_A     = 8'h20;
    localparam logic [7:0]  ADDR_USER_B     = 8'h24;
    localparam logic [7:0]  ADDR_USER_C     = 8'h28;
    localparam logic [7:0]  ADDR_DUTY       = 8'h2C;

    localparam int unsigned CMD_ON_BIT      = 0;
    localparam int unsigned CMD_TUNE_BIT    = 1;
    localparam int unsigned CMD_SAVE_BIT    = 2;

    localparam logic [6:0]  GAIN_RESET      = 7'h32;
    localparam logic [6:0]  GAIN_MAX        = 7'h64;
    localparam logic [6:0]  GAIN_MIN        = 7'h0A;

    localparam logic [15:0] SAFE_A          = 16'h0400;
    localparam logic [15:0] SAFE_B          = 16'hF900;
    localparam logic [15:0] SAFE_C          = 16'h0300;
    localparam logic [15:0] USER_A_RESET    = 16'h0100;
    localparam logic [15:0] USER_B_RESET    = 16'hFE80;
    localparam logic [15:0] USER_C_RESET    = 16'h0080;

    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    localparam logic [7:0]  PWM_PERIOD      = 8'hFF;

    typedef enum logic [1:0] { ONOFF_PIN, ONOFF_ALWAYS, ONOFF_BUS } onoff_mode_e;
    typedef enum logic [1:0] { TUNE_OFF, TUNE_ONCE, TUNE_SEC, TUNE_MIN } tune_mode_e;
    typedef enum logic [1:0] { T_IDLE, T_RAMP, T_RUN } tune_state_e;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
    } coef_s;

endpackage

// ### logic/pid_pwm.sv
// Digital PID compensator driving a fixed-frequency PWM output.
`timescale 1ns/1ps
module pid_pwm
    import loop_autotune_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        run_i,
    input  wire logic [15:0] error_i,
    input  wire coef_s       coef_i,
    output logic             pwm_o,
    output logic [7:0]       duty_o
);
    typedef struct packed {
        logic [15:0] e1;
        logic [15:0] e2;
        logic [31:0] acc;
        logic [7:0]  cnt;
        logic [7:0]  duty;
        logic        pwm;
    } pp_s;

    pp_s st_ff;
    pp_s nxt_st;
    logic [31:0] term;

    always_comb
    begin
        nxt_st = st_ff;
        // Operands are widened before the multiply so that no product loses its upper bits.
        term   = 32'($signed(coef_i.a)) * 32'($signed(error_i))
               + 32'($signed(coef_i.b)) * 32'($signed(st_ff.e1))
               + 32'($signed(coef_i.c)) * 32'($signed(st_ff.e2));
        nxt_st.cnt = st_ff.cnt + 8'h01;
        if (!run_i)
        begin
            nxt_st = '0;
        end
        else if (st_ff.cnt == PWM_PERIOD)
        begin
            // Incremental form: the integral sits in acc, updated once per PWM period.
            nxt_st.acc  = st_ff.acc + term;
            nxt_st.e2   = st_ff.e1;
            nxt_st.e1   = error_i;
            nxt_st.duty = nxt_st.acc[31] ? 8'h00 : nxt_st.acc[23:16];
        end
        nxt_st.pwm = run_i && (st_ff.cnt < st_ff.duty);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign pwm_o  = st_ff.pwm;
    assign duty_o = st_ff.duty;
endmodule

// ### logic/loop_autotune_onoff_control.sv
// Remote on/off, loop autotune sequencing and coefficient storage with an AXI4-Lite register slave.
//
// Functional notes
// - Default mode: output on while remote pin high, off when pin grounded.
// - Bus modes: always on, or on/off commanded only by bus writes.
// - Tuning starts after ramp-up completes, then its coefficient set is applied.
// - A tuning run completes between fifty and two hundred milliseconds.
// - Tune modes: off, once per enable, every second, every minute.
// - Option: tune only after first ramp since power-up, reuse later.
// - Power cycling clears the stored result so a fresh run follows.
// - Without the option, every ramp-up is followed by a tuning run.
// - A bus tune-trigger command starts the tuning algorithm.
// - Tuning result scaled by gain percent, ten to hundred, default fifty.
// - Loop uses only working coefficients, filled at reset from defaults and user store.
// - With tuning enabled at reset, load the safe default set, not user set.
// - Found tuned set is written into working coefficients and used.
// - Save command copies working coefficients into user store.
// - Tuning switched off to on loads the safe default set.
// - Tuning switched on to off reloads the user set into working coefficients.
// - Fixed-frequency PWM driven by PID on error with bus-set coefficients.
// - With tuning disabled at reset, the user set is loaded and used; tune mode resets to once here, so reset always loads the safe set.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module loop_autotune_onoff_control
    import loop_autotune_pkg::*;
#(
    parameter int unsigned TUNE_CYC = TUNE_MIN_CYC,
    parameter int unsigned RAMP_CYC = 5000,
    parameter int unsigned SEC_CNT  = SEC_CYC,
    parameter int unsigned MIN_CNT  = MIN_CYC
)
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        remote_on_i,
    input  wire logic [15:0] error_i,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             out_enable_o,
    output logic             tune_busy_o,
    output logic             pwm_o
);
    typedef struct packed {
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        onoff_mode_e onoff_mode;
        logic        bus_on;
        tune_mode_e  tune_mode;
        logic        first_only;
        logic [6:0]  gain;
        coef_s       coef;
        coef_s       user;
        coef_s       held;
        logic        held_valid;
        logic        init_done;
        tune_state_e tstate;
        logic [31:0] tcnt;
        logic [31:0] tbase;
        logic        enable;
        logic        tuned_once;
        logic [31:0] tune_count;
    } st_s;

    st_s         st_ff;
    st_s         nxt_st;
    logic        wr_go;
    logic        want_on;
    logic        manual_trig;
    logic        periodic_due;
    logic [31:0] period_cyc;
    logic [7:0]  duty;
    coef_s       found;

    // Tuned set is the safe set scaled by gain percent; a real measurement would replace this.
    function automatic logic [15:0] scale(input logic [15:0] v, input logic [6:0] g);
        logic [31:0] p;
        p = 32'($signed(v)) * 32'($signed({1'b0, g})) / 32'sd100;
        return p[15:0];
    endfunction

    always_comb
    begin
        nxt_st       = st_ff;
        wr_go        = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
        manual_trig  = 1'b0;
        period_cyc   = (st_ff.tune_mode == TUNE_MIN) ? MIN_CNT : SEC_CNT;
        periodic_due = 1'b0;
        found.a      = scale(SAFE_A, st_ff.gain);
        found.b      = scale(SAFE_B, st_ff.gain);
        found.c      = scale(SAFE_C, st_ff.gain);

        if (!st_ff.init_done)
        begin
            nxt_st.init_done = 1'b1;
            nxt_st.coef      = (st_ff.tune_mode != TUNE_OFF) ? coef_s'{SAFE_A, SAFE_B, SAFE_C} : st_ff.user;
        end

        if (s_axi_awvalid && !st_ff.aw_got)
        begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !st_ff.w_got)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready)
            nxt_st.bvalid = 1'b0;
        if (wr_go)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = RESP_OKAY;
            unique case (st_ff.awaddr)
                ADDR_CTRL:
                    if (st_ff.wstrb[0])
                        nxt_st.onoff_mode = onoff_mode_e'((st_ff.wdata[1:0] == 2'b11) ? 2'b00 : st_ff.wdata[1:0]);
                ADDR_TUNE_CFG:
                    if (st_ff.wstrb[0])
                    begin
                        nxt_st.tune_mode  = tune_mode_e'(st_ff.wdata[1:0]);
                        nxt_st.first_only = st_ff.wdata[2];
                        if (st_ff.tune_mode == TUNE_OFF && st_ff.wdata[1:0] != 2'b00)
                            nxt_st.coef = coef_s'{SAFE_A, SAFE_B, SAFE_C};
                        else if (st_ff.tune_mode != TUNE_OFF && st_ff.wdata[1:0] == 2'b00)
                        begin
                            nxt_st.coef   = st_ff.user;
                            nxt_st.tstate = (st_ff.tstate == T_RUN) ? T_IDLE : st_ff.tstate;
                        end
                    end
                ADDR_GAIN:
                    if (st_ff.wstrb[0])
                        nxt_st.gain = (st_ff.wdata[6:0] > GAIN_MAX) ? GAIN_MAX :
                                      (st_ff.wdata[6:0] < GAIN_MIN) ? GAIN_MIN : st_ff.wdata[6:0];
                ADDR_CMD:
                    if (st_ff.wstrb[0])
                    begin
                        nxt_st.bus_on = st_ff.wdata[CMD_ON_BIT];
                        manual_trig   = st_ff.wdata[CMD_TUNE_BIT] && st_ff.enable;
                        if (st_ff.wdata[CMD_SAVE_BIT])
                            nxt_st.user = st_ff.coef;
                    end
                ADDR_COEF_A:
                    nxt_st.coef.a = st_ff.wdata[15:0];
                ADDR_COEF_B:
                    nxt_st.coef.b = st_ff.wdata[15:0];
                ADDR_COEF_C:
                    nxt_st.coef.c = st_ff.wdata[15:0];
                ADDR_USER_A:
                    nxt_st.user.a = st_ff.wdata[15:0];
                ADDR_USER_B:
                    nxt_st.user.b = st_ff.wdata[15:0];
                ADDR_USER_C:
                    nxt_st.user.c = st_ff.wdata[15:0];
                default:
                    nxt_st.bresp = RESP_SLVERR;
            endcase
        end

        if (st_ff.rvalid && s_axi_rready)
            nxt_st.rvalid = 1'b0;
        if (s_axi_arvalid && !st_ff.rvalid)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = RESP_OKAY;
            unique case (s_axi_araddr[7:0])
                ADDR_CTRL:     nxt_st.rdata = {30'h0, st_ff.onoff_mode};
                ADDR_TUNE_CFG: nxt_st.rdata = {29'h0, st_ff.first_only, st_ff.tune_mode};
                ADDR_GAIN:     nxt_st.rdata = {25'h0, st_ff.gain};
                ADDR_CMD:      nxt_st.rdata = {31'h0, st_ff.bus_on};
                ADDR_STATUS:   nxt_st.rdata = {st_ff.tune_count[27:0], st_ff.held_valid,
                                               st_ff.tstate == T_RUN, st_ff.tstate == T_RAMP, st_ff.enable};
                ADDR_COEF_A:   nxt_st.rdata = {16'h0, st_ff.coef.a};
                ADDR_COEF_B:   nxt_st.rdata = {16'h0, st_ff.coef.b};
                ADDR_COEF_C:   nxt_st.rdata = {16'h0, st_ff.coef.c};
                ADDR_USER_A:   nxt_st.rdata = {16'h0, st_ff.user.a};
                ADDR_USER_B:   nxt_st.rdata = {16'h0, st_ff.user.b};
                ADDR_USER_C:   nxt_st.rdata = {16'h0, st_ff.user.c};
                ADDR_DUTY:     nxt_st.rdata = {24'h0, duty};
                default:
                begin
                    nxt_st.rdata = 32'h0000_0000;
                    nxt_st.rresp = RESP_SLVERR;
                end
            endcase
        end

        unique case (st_ff.onoff_mode)
            ONOFF_PIN:    want_on = remote_on_i;
            ONOFF_ALWAYS: want_on = 1'b1;
            ONOFF_BUS:    want_on = st_ff.bus_on;
            default:      want_on = 1'b0;
        endcase
        nxt_st.enable = want_on && st_ff.init_done;

        // Periodic runs count from the last trigger so that manual runs also reset the interval.
        nxt_st.tbase = st_ff.tbase + 32'd1;
        if ((st_ff.tune_mode == TUNE_SEC || st_ff.tune_mode == TUNE_MIN) && st_ff.tbase >= period_cyc - 32'd1)
            periodic_due = 1'b1;

        unique case (st_ff.tstate)
            T_IDLE:
            begin
                if (nxt_st.enable && !st_ff.enable)
                begin
                    nxt_st.tstate = T_RAMP;
                    nxt_st.tcnt   = 32'd0;
                end
                else if (st_ff.enable && st_ff.tune_mode != TUNE_OFF && (manual_trig || periodic_due))
                begin
                    nxt_st.tstate = T_RUN;
                    nxt_st.tcnt   = 32'd0;
                    nxt_st.tbase  = 32'd0;
                end
            end
            T_RAMP:
            begin
                nxt_st.tcnt = st_ff.tcnt + 32'd1;
                if (st_ff.tcnt >= RAMP_CYC - 32'd1)
                begin
                    nxt_st.tcnt = 32'd0;
                    if (st_ff.tune_mode == TUNE_OFF)
                        nxt_st.tstate = T_IDLE;
                    else if (st_ff.first_only && st_ff.held_valid)
                    begin
                        nxt_st.tstate = T_IDLE;
                        nxt_st.coef   = st_ff.held;
                    end
                    else
                    begin
                        nxt_st.tstate = T_RUN;
                        nxt_st.tbase  = 32'd0;
                    end
                end
            end
            T_RUN:
            begin
                nxt_st.tcnt = st_ff.tcnt + 32'd1;
                if (st_ff.tcnt >= TUNE_CYC - 32'd1)
                begin
                    nxt_st.tstate     = T_IDLE;
                    nxt_st.coef       = found;
                    nxt_st.held       = found;
                    nxt_st.held_valid = 1'b1;
                    nxt_st.tune_count = st_ff.tune_count + 32'd1;
                end
            end
        endcase
        if (!nxt_st.enable && st_ff.tstate != T_IDLE)
            nxt_st.tstate = T_IDLE;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff            <= '0;
            st_ff.onoff_mode <= ONOFF_PIN;
            st_ff.tune_mode  <= TUNE_ONCE;
            st_ff.gain       <= GAIN_RESET;
            st_ff.user       <= coef_s'{USER_A_RESET, USER_B_RESET, USER_C_RESET};
            st_ff.tstate     <= T_IDLE;
            // Power-up clears the held result, forcing a fresh run.
            st_ff.held_valid <= 1'b0;
        end
        else
            st_ff <= nxt_st;
    end

    pid_pwm u_pid_pwm (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .run_i      (st_ff.enable),
        .error_i    (error_i),
        .coef_i     (st_ff.coef),
        .pwm_o      (pwm_o),
        .duty_o     (duty)
    );

    assign s_axi_awready = !st_ff.aw_got;
    assign s_axi_wready  = !st_ff.w_got;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;
    assign out_enable_o  = st_ff.enable;
    assign tune_busy_o   = (st_ff.tstate == T_RUN);
endmodule

// ### test/loop_autotune_onoff_control_properties.sv
// Port-level checks for the loop autotune and on/off controller.
`timescale 1ns/1ps
module loop_autotune_onoff_control_properties #(
    parameter int unsigned TUNE_CYC = 20
)
(
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        out_enable_o,
    input wire logic        tune_busy_o
);
    logic [31:0] busy_cnt_ff;
    logic [31:0] nxt_busy_cnt;

    default clocking dcb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // A run is timed by counting busy cycles, since the full window is too long for a repetition.
    always_comb nxt_busy_cnt = tune_busy_o ? busy_cnt_ff + 32'h1 : 32'h0;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            busy_cnt_ff <= 32'h0;
        else
            busy_cnt_ff <= nxt_busy_cnt;
    end

    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    chk_wr_answer: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    chk_wr_refuse: assert property (wr_both |=> !s_axi_awready && !s_axi_wready)
        else $error("second write taken before the first was answered");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    chk_rd_answer: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data late");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_ramp_wait: assert property ($rose(out_enable_o) |-> !tune_busy_o [*8])
        else $error("tuning began before ramp-up ended");
    chk_busy_enabled: assert property ($rose(tune_busy_o) |-> out_enable_o)
        else $error("tuning began with output disabled");
    chk_tune_length: assert property ($fell(tune_busy_o) && out_enable_o |-> busy_cnt_ff == TUNE_CYC)
        else $error("tuning run has wrong length");
endmodule

bind loop_autotune_onoff_control loop_autotune_onoff_control_properties #(.TUNE_CYC(TUNE_CYC)) i_props (.*);

// ### test/pmbus_host_model.sv
// Host model: register bus master and remote on/off pin driver.
`timescale 1ns/1ps
module pmbus_host_model (
    input  wire logic        core_clk_i,
    output logic [31:0]      s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [31:0]      s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready,
    output logic             remote_on_o
);
    // Answer wait in cycles, to model a slow host.
    int         stall  = 0;
    logic [3:0] strobe = 4'hF;

    initial
    begin
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, remote_on_o} = '0;
    end

    // Released payloads are inverted so a slave cannot rely on stale values.
    task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, output bit to);
        to = 1'b1;
        @(posedge core_clk_i);
        s_axi_awaddr  <= {24'h0, a};
        s_axi_wdata   <= d;
        s_axi_wstrb   <= strobe;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= (stall == 0);
        for (int n = 0; n < 64; n++)
        begin
            @(posedge core_clk_i);
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~s_axi_wdata;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bready <= 1'b0;
                r = s_axi_bresp;
                to = 1'b0;
                break;
            end
            if (n >= stall)
                s_axi_bready <= 1'b1;
        end
    endtask

    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output bit to);
        to = 1'b1;
        @(posedge core_clk_i);
        s_axi_araddr  <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= (stall == 0);
        for (int n = 0; n < 64; n++)
        begin
            @(posedge core_clk_i);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~s_axi_araddr;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rready <= 1'b0;
                d = s_axi_rdata;
                r = s_axi_rresp;
                to = 1'b0;
                break;
            end
            if (n >= stall)
                s_axi_rready <= 1'b1;
        end
    endtask

    // The clock runs from time zero, so it is stable before the pin is ever raised.
    task automatic pin(input logic v);
        @(posedge core_clk_i);
        remote_on_o <= v;
    endtask
endmodule

// ### test/loop_autotune_onoff_control_tb_top.sv
// Self-checking bench for the loop autotune and on/off controller.
`timescale 1ns/1ps
module loop_autotune_onoff_control_tb_top
    import loop_autotune_pkg::*;
;
    localparam int TUNE_N = 20;
    localparam int RAMP_N = 10;
    logic        core_clk_i, rst_n_i, remote_on_i, out_enable_o, tune_busy_o, pwm_o, to;
    logic [15:0] error_i;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  gin [3] = '{8'h05, 8'h7F, 8'h64};
    logic [7:0]  gout [3] = '{8'h0A, 8'h64, 8'h64};
    int          fails = 0;
    int          tests_run = 0;

    loop_autotune_onoff_control #(.TUNE_CYC(TUNE_N), .RAMP_CYC(RAMP_N), .SEC_CNT(100), .MIN_CNT(300)) i_dut (.*);

    pmbus_host_model i_host (.*, .remote_on_o(remote_on_i));

    task automatic conclude();
        if (fails == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic guard(input logic bad);
        if (bad)
        begin
            fails++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_host.write(a, v, r, to);
        guard(to);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        i_host.read(a, d, r, to);
        guard(to);
        chk(d, exp);
    endtask

    // Waits on the busy or enable output; a wait that runs out ends the run.
    task automatic wait_on(input logic busy, input logic v, input int n);
        int k;
        for (k = 0; k < n; k++)
        begin
            @(posedge core_clk_i);
            if ((busy ? tune_busy_o : out_enable_o) === v)
                break;
        end
        guard(k == n);
    endtask

    task automatic quiet(input int n);
        int hits = 0;
        repeat (n)
        begin
            @(posedge core_clk_i);
            hits += (tune_busy_o !== 1'b0);
        end
        chk(32'(hits), 32'h0);
    endtask

    task automatic run_tune();
        wait_on(1'b1, 1'b1, RAMP_N + 8);
        wait_on(1'b1, 1'b0, TUNE_N + 8);
    endtask

    initial
    begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        guard(1'b1);
    end

    initial
    begin
        rst_n_i = 1'b0;
        error_i = 16'h0010;
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd_chk(ADDR_GAIN, 32'h32);
        rd_chk(ADDR_TUNE_CFG, 32'h1);
        rd_chk(ADDR_COEF_A, 32'(SAFE_A));
        i_host.stall = 3;
        i_host.read(8'h30, d, r, to);
        i_host.stall = 0;
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk({31'h0, out_enable_o}, 32'h0);
        i_host.pin(1'b1);
        wait_on(1'b0, 1'b1, 8);
        run_tune();
        rd_chk(ADDR_COEF_A, 32'(SAFE_A) * 50 / 100);
        rd_chk(ADDR_COEF_C, 32'(SAFE_C) * 50 / 100);
        foreach (gin[i])
        begin
            wr(ADDR_GAIN, {24'h0, gin[i]});
            rd_chk(ADDR_GAIN, {24'h0, gout[i]});
        end
        i_host.strobe = 4'hE;
        wr(ADDR_GAIN, 32'h14);
        i_host.strobe = 4'hF;
        rd_chk(ADDR_GAIN, 32'h64);
        wr(ADDR_CMD, 32'h2);
        run_tune();
        rd_chk(ADDR_COEF_A, 32'(SAFE_A));
        i_host.pin(1'b0);
        wait_on(1'b0, 1'b0, 8);
        error_i <= 16'h1000;
        wr(ADDR_CTRL, 32'h1);
        wait_on(1'b0, 1'b1, 8);
        run_tune();
        repeat (800) @(posedge core_clk_i);
        rd_chk(ADDR_DUTY, 32'h10);
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_CMD, 32'h0);
        wait_on(1'b0, 1'b0, 8);
        rd_chk(ADDR_DUTY, 32'h0);
        chk({31'h0, pwm_o}, 32'h0);
        wr(ADDR_CMD, 32'h1);
        wait_on(1'b0, 1'b1, 8);
        run_tune();
        wr(ADDR_USER_A, 32'h1234);
        wr(ADDR_TUNE_CFG, 32'h0);
        rd_chk(ADDR_COEF_A, 32'h1234);
        wr(ADDR_TUNE_CFG, 32'h1);
        rd_chk(ADDR_COEF_A, 32'(SAFE_A));
        wr(ADDR_CMD, 32'h5);
        rd_chk(ADDR_USER_A, 32'(SAFE_A));
        wr(ADDR_TUNE_CFG, 32'h2);
        wr(ADDR_CMD, 32'h3);
        run_tune();
        quiet(50);
        wait_on(1'b1, 1'b1, 60);
        wait_on(1'b1, 1'b0, TUNE_N + 8);
        wr(ADDR_TUNE_CFG, 32'h3);
        rd_chk(ADDR_TUNE_CFG, 32'h3);
        quiet(60);
        wait_on(1'b1, 1'b1, 320);
        wait_on(1'b1, 1'b0, TUNE_N + 8);
        // A reset after the run has ended stands in for cycling input power.
        rst_n_i <= 1'b0;
        i_host.pin(1'b0);
        rst_n_i <= 1'b1;
        wr(ADDR_TUNE_CFG, 32'h5);
        i_host.pin(1'b1);
        run_tune();
        i_host.pin(1'b0);
        wait_on(1'b0, 1'b0, 8);
        i_host.pin(1'b1);
        wait_on(1'b0, 1'b1, 8);
        quiet(40);
        conclude();
    end
endmodule
